// file: design/vbce_top.v
// vbce_top.v: read value and write value command executor
// assumes: host loads parameter bytes then pulses start; the tag side answers
// block reads, writes and authentication with done pulses on ref_clk_i
// Function
// - read value params: block 0, buffer offset 1, key selector 2, key 3.
// - read value parses block as value: signed 32-bit value plus address byte.
// - on success value goes to buffer at offset, address byte right after.
// - value stored lowest byte first, address as unsigned byte.
// - write value params: block 0, value 1-4, address 5, selector 6, key 7.
// - supplied value is signed 32-bit, lowest byte first.
// - write value puts the address byte into the block's last four bytes.
// - selector low six bits pick stored key 0 to 39.
// - selector bit 7 set means key B, clear means key A.
// - selector bit 6 set takes the six following parameter bytes as key.
// - inline key is least significant byte first.
// - write value formats the whole block in value layout.
`timescale 1ns/1ns
`default_nettype none
`include "vbce_defines.vh"

module vbce_top (
	// clock and reset
	input  wire         ref_clk_i,
	input  wire         reset_n_i,
	// host command port
	input  wire         start_i,
	input  wire [7:0]   cmd_i,
	input  wire         param_we_i,
	input  wire [4:0]   param_addr_i,
	input  wire [7:0]   param_data_i,
	// host buffer read port
	input  wire [7:0]   buf_raddr_i,
	output reg  [7:0]   buf_rdata_o,
	// host status
	output wire         busy_o,
	output reg          done_o,
	output reg  [1:0]   result_o,
	// tag side authentication
	output reg          auth_req_o,
	output reg  [7:0]   auth_block_o,
	output reg          auth_key_b_o,
	output reg          auth_inline_o,
	output reg  [5:0]   auth_key_idx_o,
	output reg  [47:0]  auth_key_o,
	input  wire         auth_done_i,
	input  wire         auth_ok_i,
	// tag side block access
	output reg          blk_rd_req_o,
	output reg          blk_wr_req_o,
	output reg  [7:0]   blk_addr_o,
	output reg  [127:0] blk_wdata_o,
	input  wire         blk_done_i,
	input  wire         blk_ok_i,
	input  wire [127:0] blk_rdata_i
);

	// sequencer states
	localparam ST_IDLE  = 3'h0;
	localparam ST_AUTH  = 3'h1;
	localparam ST_WAIT  = 3'h2;
	localparam ST_BLK   = 3'h3;
	localparam ST_BWAIT = 3'h4;
	localparam ST_STORE = 3'h5;
	localparam ST_DONE  = 3'h6;

	// parameter area and data buffer; neither is reset, the host loads before use
	reg  [7:0]   param_mem [0:`VBCE_PARAM_DEPTH-1];
	reg  [7:0]   buf_mem   [0:`VBCE_BUF_DEPTH-1];
	// sequencer state and the captured read result
	reg  [2:0]   state_reg;
	reg  [2:0]   state_next;
	reg          is_write_reg;
	reg  [1:0]   res_reg;
	reg  [31:0]  rd_value_reg;
	reg  [7:0]   rd_addr_reg;
	reg  [2:0]   store_cnt_reg;
	reg  [7:0]   store_ptr_reg;
	// key selection for the running command
	reg  [7:0]   key_sel;
	reg  [4:0]   key_base;
	reg  [47:0]  inline_key;
	// value block formatter and parser
	wire [31:0]  wr_value;
	wire [127:0] fmt_block;
	wire [31:0]  prs_value;
	wire [7:0]   prs_addr;
	wire         prs_valid;
	reg  [7:0]   store_byte;
	integer      k;

	// busy is a handshake output, decoded straight from the state
	assign busy_o = (state_reg != ST_IDLE);

	// host parameter area writes
	// refused while busy so the running command's parameters cannot shift under it
	always @(posedge ref_clk_i) begin
		if (param_we_i && !busy_o) begin
			param_mem[param_addr_i] <= param_data_i;
		end
	end

	// read value selector at offset 2; write value selector at 6
	always @* begin
		if (is_write_reg) begin
			key_sel  = param_mem[`VBCE_WR_KEYSEL_OFS];
			key_base = `VBCE_WR_KEY_OFS;
		end else begin
			key_sel  = param_mem[`VBCE_RD_KEYSEL_OFS];
			key_base = `VBCE_RD_KEY_OFS;
		end
	end

	// inline key gathered least significant byte first
	always @* begin
		inline_key = 48'h0;
		// the six key bytes follow the selector at the command's own key offset
		for (k = 0; k < `VBCE_KEY_BYTES; k = k + 1) begin
			inline_key[k*8 +: 8] = param_mem[key_base + k[4:0]];
		end
	end

	// write value bytes lowest first
	// the sign is kept as raw bits; nothing here extends or checks it
	assign wr_value = {param_mem[`VBCE_WR_VAL_OFS + 5'h03], param_mem[`VBCE_WR_VAL_OFS + 5'h02],
			param_mem[`VBCE_WR_VAL_OFS + 5'h01], param_mem[`VBCE_WR_VAL_OFS]};

	// address byte in last four bytes; whole block in value layout
	vbce_value_format u_format (
		.value_i (wr_value),
		.addr_i  (param_mem[`VBCE_WR_ADR_OFS]),
		.block_o (fmt_block)
	);

	// parse returned block as a value block
	vbce_value_parse u_parse (
		.block_i (blk_rdata_i),
		.value_o (prs_value),
		.addr_o  (prs_addr),
		.valid_o (prs_valid)
	);

	// next state
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start_i) begin
					if (cmd_i == `VBCE_CMD_READ_VALUE || cmd_i == `VBCE_CMD_WRITE_VALUE) begin
						state_next = ST_AUTH;
					end else begin
						state_next = ST_DONE;
					end
				end
			end
			// a refused stored key index is turned to ST_DONE in the sequencer
			ST_AUTH:  state_next = ST_WAIT;
			ST_WAIT: begin
				if (auth_done_i) begin
					state_next = auth_ok_i ? ST_BLK : ST_DONE;
				end
			end
			ST_BLK:   state_next = ST_BWAIT;
			ST_BWAIT: begin
				if (blk_done_i) begin
					if (!is_write_reg && blk_ok_i && prs_valid) begin
						state_next = ST_STORE;
					end else begin
						state_next = ST_DONE;
					end
				end
			end
			// five stores: four value bytes, then the address byte
			ST_STORE: begin
				if (store_cnt_reg == `VBCE_VALUE_BYTES) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE:  state_next = ST_IDLE;
			default:  state_next = ST_IDLE;
		endcase
	end

	// value bytes lowest first, then unsigned address byte
	always @* begin
		case (store_cnt_reg)
			3'h0:    store_byte = rd_value_reg[7:0];
			3'h1:    store_byte = rd_value_reg[15:8];
			3'h2:    store_byte = rd_value_reg[23:16];
			3'h3:    store_byte = rd_value_reg[31:24];
			default: store_byte = rd_addr_reg;
		endcase
	end

	// buffer written from offset, address after value
	// only the store state writes, so a failed command leaves it alone
	always @(posedge ref_clk_i) begin
		if (state_reg == ST_STORE) begin
			buf_mem[store_ptr_reg] <= store_byte;
		end
		// registered read port, one cycle behind the address
		if (!reset_n_i) begin
			buf_rdata_o <= 8'h00;
		end else begin
			buf_rdata_o <= buf_mem[buf_raddr_i];
		end
	end

	// sequencer registers and tag side requests
	always @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			state_reg      <= ST_IDLE;
			is_write_reg   <= 1'b0;
			res_reg        <= `VBCE_RES_OK;
			rd_value_reg   <= 32'h0;
			rd_addr_reg    <= 8'h0;
			store_cnt_reg  <= 3'h0;
			store_ptr_reg  <= 8'h0;
			done_o         <= 1'b0;
			result_o       <= `VBCE_RES_OK;
			auth_req_o     <= 1'b0;
			auth_block_o   <= 8'h0;
			auth_key_b_o   <= 1'b0;
			auth_inline_o  <= 1'b0;
			auth_key_idx_o <= 6'h0;
			auth_key_o     <= 48'h0;
			blk_rd_req_o   <= 1'b0;
			blk_wr_req_o   <= 1'b0;
			blk_addr_o     <= 8'h0;
			blk_wdata_o    <= 128'h0;
		end else begin
			state_reg    <= state_next;
			done_o       <= 1'b0;
			auth_req_o   <= 1'b0;
			blk_rd_req_o <= 1'b0;
			blk_wr_req_o <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (start_i) begin
						is_write_reg  <= (cmd_i == `VBCE_CMD_WRITE_VALUE);
						// assume an unknown code until the command proves otherwise
						res_reg       <= `VBCE_RES_BAD_CMD;
						store_cnt_reg <= 3'h0;
					end
				end
				ST_AUTH: begin
					auth_req_o     <= 1'b1;
					auth_block_o   <= param_mem[`VBCE_RD_BLK_OFS];
					// low six bits give stored key index
					auth_key_idx_o <= key_sel[`VBCE_KSEL_IDX_MSB:0];
					auth_key_b_o   <= key_sel[`VBCE_KSEL_KEYB_BIT];
					auth_inline_o  <= key_sel[`VBCE_KSEL_INLINE_BIT];
					auth_key_o     <= key_sel[`VBCE_KSEL_INLINE_BIT] ? inline_key : 48'h0;
					// index above 39 rejected
					// these assignments come last, so they win over the defaults above
					if (!key_sel[`VBCE_KSEL_INLINE_BIT] && key_sel[`VBCE_KSEL_IDX_MSB:0] > `VBCE_KEY_IDX_MAX) begin
						auth_req_o <= 1'b0;
						res_reg    <= `VBCE_RES_AUTH_FAIL;
						state_reg  <= ST_DONE;
					end
				end
				ST_WAIT: begin
					if (auth_done_i && !auth_ok_i) begin
						res_reg <= `VBCE_RES_AUTH_FAIL;
					end
				end
				ST_BLK: begin
					blk_addr_o   <= param_mem[`VBCE_RD_BLK_OFS];
					blk_wdata_o  <= fmt_block;
					blk_rd_req_o <= !is_write_reg;
					blk_wr_req_o <= is_write_reg;
				end
				ST_BWAIT: begin
					if (blk_done_i) begin
						// latched even on failure; only ST_STORE ever writes the buffer
						rd_value_reg  <= prs_value;
						rd_addr_reg   <= prs_addr;
						store_ptr_reg <= param_mem[`VBCE_RD_BUF_OFS];
						if (blk_ok_i && (is_write_reg || prs_valid)) begin
							res_reg <= `VBCE_RES_OK;
						end else begin
							res_reg <= `VBCE_RES_FORMAT_FAIL;
						end
					end
				end
				ST_STORE: begin
					store_cnt_reg <= store_cnt_reg + 3'h1;
					store_ptr_reg <= store_ptr_reg + 8'h01;
				end
				ST_DONE: begin
					done_o   <= 1'b1;
					// result_o holds until the next command completes
					result_o <= res_reg;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

endmodule // vbce_top
`default_nettype wire

// file: design/vbce_defines.vh
// vbce_defines.vh: constants for the value block command executor
// assumes: included by vbce_top by bare name
`ifndef VBCE_DEFINES_VH
`define VBCE_DEFINES_VH

// command codes
`define VBCE_CMD_READ_VALUE   8'h0A
`define VBCE_CMD_WRITE_VALUE  8'h0B

// read value parameter offsets
`define VBCE_RD_BLK_OFS       5'h00
`define VBCE_RD_BUF_OFS       5'h01
`define VBCE_RD_KEYSEL_OFS    5'h02
`define VBCE_RD_KEY_OFS       5'h03

// write value parameter offsets
`define VBCE_WR_BLK_OFS       5'h00
`define VBCE_WR_VAL_OFS       5'h01
`define VBCE_WR_ADR_OFS       5'h05
`define VBCE_WR_KEYSEL_OFS    5'h06
`define VBCE_WR_KEY_OFS       5'h07

// key selector fields
`define VBCE_KSEL_IDX_MSB     5
`define VBCE_KSEL_INLINE_BIT  6
`define VBCE_KSEL_KEYB_BIT    7
`define VBCE_KEY_IDX_MAX      6'h27

// sizes
`define VBCE_KEY_BYTES        4'h6
`define VBCE_BLOCK_BYTES      5'h10
`define VBCE_VALUE_BYTES      3'h4
`define VBCE_PARAM_DEPTH      32
`define VBCE_BUF_DEPTH        256

// result codes
`define VBCE_RES_OK           2'h0
`define VBCE_RES_AUTH_FAIL    2'h1
`define VBCE_RES_FORMAT_FAIL  2'h2
`define VBCE_RES_BAD_CMD      2'h3

`endif

// file: design/vbce_value_parse.v
// vbce_value_parse.v: checks a 16-byte block against the value layout
// assumes: block bytes arrive flat, byte 0 in the low bits
`timescale 1ns/1ns
`default_nettype none

module vbce_value_parse (
	// block image
	input  wire [127:0] block_i,
	// parse results
	output wire [31:0]  value_o,
	output wire [7:0]   addr_o,
	output wire         valid_o
);

	wire [31:0] val_a;
	wire [31:0] val_inv;
	wire [31:0] val_b;
	wire [7:0]  adr0;
	wire [7:0]  adr1;
	wire [7:0]  adr2;
	wire [7:0]  adr3;

	// value, its complement and its copy, then address and complement pairs
	assign val_a   = block_i[31:0];
	assign val_inv = block_i[63:32];
	assign val_b   = block_i[95:64];
	assign adr0    = block_i[103:96];
	assign adr1    = block_i[111:104];
	assign adr2    = block_i[119:112];
	assign adr3    = block_i[127:120];

	assign valid_o = (val_a == val_b) && (val_a == ~val_inv) && (adr0 == adr2) && (adr1 == adr3) && (adr0 == ~adr1);
	assign value_o = val_a;
	assign addr_o  = adr0;

endmodule // vbce_value_parse
`default_nettype wire

// file: design/vbce_value_format.v
// vbce_value_format.v: builds a 16-byte value block from value and address
// assumes: purely combinational, byte 0 in the low bits
`timescale 1ns/1ns
`default_nettype none

module vbce_value_format (
	// inputs
	input  wire [31:0]  value_i,
	input  wire [7:0]   addr_i,
	// block image
	output wire [127:0] block_o
);

	// value, inverted value, value, then address pattern in last four bytes
	assign block_o = {~addr_i, addr_i, ~addr_i, addr_i, value_i, ~value_i, value_i};

endmodule // vbce_value_format
`default_nettype wire

// file: verification/vbce_asserts.sv
// vbce_asserts.sv: port checker for the value block executor
// assumes: bound to vbce_top; the tag answers only to requests
`timescale 1ns/1ns
`default_nettype none
module vbce_asserts (
	// clock and reset
	input wire logic         ref_clk_i,
	input wire logic         reset_n_i,
	// host side
	input wire logic         start_i,
	input wire logic [7:0]   cmd_i,
	input wire logic         busy_o,
	input wire logic         done_o,
	input wire logic [1:0]   result_o,
	// tag side
	input wire logic         auth_req_o,
	input wire logic         auth_inline_o,
	input wire logic [5:0]   auth_key_idx_o,
	input wire logic [47:0]  auth_key_o,
	input wire logic         auth_done_i,
	input wire logic         auth_ok_i,
	input wire logic         blk_rd_req_o,
	input wire logic         blk_wr_req_o,
	input wire logic [127:0] blk_wdata_o,
	input wire logic         blk_done_i,
	input wire logic         blk_ok_i,
	input wire logic [127:0] blk_rdata_i
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// value layout: copies and complements of value and address
	function automatic logic vb(input logic [127:0] b);
		return b[63:32] == ~b[31:0] && b[95:64] == b[31:0]
			&& b[111:96] == {~b[103:96], b[103:96]} && b[127:112] == b[111:96];
	endfunction
	// a block read is outstanding
	logic rd_pend;
	always @(posedge ref_clk_i) begin
		if (!reset_n_i || blk_done_i)
			rd_pend <= 1'b0;
		else if (blk_rd_req_o)
			rd_pend <= 1'b1;
	end
	sequence s_rd_good;
		blk_done_i && rd_pend && blk_ok_i && vb(blk_rdata_i);
	endsequence
	sequence s_blk_bad;
		blk_done_i && !(blk_ok_i && (!rd_pend || vb(blk_rdata_i)));
	endsequence
	a_read_ok_done: assert property (s_rd_good |-> ##7 done_o && result_o == 2'h0)
		else $error("read value did not finish ok");
	a_block_fail: assert property (s_blk_bad |-> ##2 done_o && result_o == 2'h2)
		else $error("block failure not reported");
	a_auth_fail: assert property (auth_done_i && !auth_ok_i |-> ##2 done_o && result_o == 2'h1)
		else $error("auth failure not reported");
	a_auth_then_blk: assert property (auth_done_i && auth_ok_i |-> ##2 blk_rd_req_o || blk_wr_req_o)
		else $error("no block access after auth");
	a_start_auth: assert property (start_i && !busy_o && cmd_i inside {8'h0A, 8'h0B}
		|-> (##2 auth_req_o) or (##3 done_o && result_o == 2'h1))
		else $error("command start without auth");
	a_bad_cmd: assert property (start_i && !busy_o && !(cmd_i inside {8'h0A, 8'h0B})
		|-> ##2 done_o && result_o == 2'h3)
		else $error("unknown command not refused");
	a_key_range: assert property (auth_req_o && !auth_inline_o |-> auth_key_idx_o <= 6'h27 && auth_key_o == 48'h0)
		else $error("stored key index out of range");
	a_write_layout: assert property (blk_wr_req_o |-> vb(blk_wdata_o))
		else $error("written block not value layout");
	a_done_pulse: assert property (done_o |-> !busy_o ##1 !done_o)
		else $error("done not a single pulse");
endmodule // vbce_asserts
`default_nettype wire

// file: verification/vbce_tag_model.sv
// vbce_tag_model.sv: behavioural tag, answers auth and block access
// assumes: one request at a time, answer after lat_i idle cycles
`timescale 1ns/1ns
`default_nettype none
module vbce_tag_model (
	// clock, reset and test controls
	input wire logic          clk_i,
	input wire logic          rst_n_i,
	input wire logic          deny_i,
	input wire logic [3:0]    lat_i,
	// requests
	input wire logic          auth_req_i,
	input wire logic          rd_req_i,
	input wire logic          wr_req_i,
	input wire logic [7:0]    addr_i,
	input wire logic [127:0]  wdata_i,
	// answers
	output logic              auth_done_o,
	output logic              auth_ok_o,
	output logic              blk_done_o,
	output logic              blk_ok_o,
	output logic [127:0]      rdata_o
);
	logic [127:0] mem [0:255];
	logic [127:0] wd;
	logic [7:0]   adr;
	logic [3:0]   cnt;
	logic [1:0]   op;
	// blocks hold a repeated byte, not a value layout, except block 9 (value 9)
	initial begin
		rdata_o = 128'h0;
		for (int i = 0; i < 256; i++)
			mem[i] = {16{i[7:0]}};
		mem[9] = {8'hF6, 8'h09, 8'hF6, 8'h09, 32'h00000009, 32'hFFFFFFF6, 32'h00000009};
	end
	// take a request, wait, answer; data toggles when not valid
	always @(posedge clk_i) begin
		auth_done_o <= 1'b0;
		blk_done_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (!rst_n_i)
			op <= 2'h0;
		else if (auth_req_i || rd_req_i || wr_req_i) begin
			op <= auth_req_i ? 2'h1 : rd_req_i ? 2'h2 : 2'h3;
			cnt <= lat_i;
			adr <= addr_i;
			wd <= wdata_i;
		end else if (op != 2'h0 && cnt != 4'h0)
			cnt <= cnt - 4'h1;
		else if (op != 2'h0) begin
			op <= 2'h0;
			auth_done_o <= op == 2'h1;
			auth_ok_o <= !deny_i;
			blk_done_o <= op != 2'h1;
			blk_ok_o <= 1'b1;
			rdata_o <= mem[adr];
			if (op == 2'h3)
				mem[adr] <= wd;
		end
	end
endmodule // vbce_tag_model
`default_nettype wire

// file: verification/testbench.sv
// testbench.sv: command sequences against vbce_top and a tag model
// assumes: vbce_top, vbce_tag_model and vbce_asserts compiled before
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk, rst_n, start, pwe, deny, busy, done, aq, akb, ai, ad, ao, brd, bwr, bd, bo;
	logic [7:0] cmd, pd, ra, rd, ab, ba;
	logic [4:0] pa;
	logic [1:0] res;
	logic [3:0] lat;
	logic [5:0] aix;
	logic [47:0] ak;
	logic [127:0] bw, br;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	vbce_top i_dut (.ref_clk_i(clk), .reset_n_i(rst_n), .start_i(start), .cmd_i(cmd),
		.param_we_i(pwe), .param_addr_i(pa), .param_data_i(pd), .buf_raddr_i(ra), .buf_rdata_o(rd),
		.busy_o(busy), .done_o(done), .result_o(res), .auth_req_o(aq), .auth_block_o(ab),
		.auth_key_b_o(akb), .auth_inline_o(ai), .auth_key_idx_o(aix), .auth_key_o(ak),
		.auth_done_i(ad), .auth_ok_i(ao), .blk_rd_req_o(brd), .blk_wr_req_o(bwr), .blk_addr_o(ba),
		.blk_wdata_o(bw), .blk_done_i(bd), .blk_ok_i(bo), .blk_rdata_i(br));
	vbce_tag_model i_tag (.clk_i(clk), .rst_n_i(rst_n), .deny_i(deny), .lat_i(lat), .auth_req_i(aq),
		.rd_req_i(brd), .wr_req_i(bwr), .addr_i(ba), .wdata_i(bw), .auth_done_o(ad), .auth_ok_o(ao),
		.blk_done_o(bd), .blk_ok_o(bo), .rdata_o(br));
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task conclude;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			conclude();
		end
	end
	task chk(input logic [127:0] seen, input logic [127:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// strobe stays high across back-to-back parameter bytes
	task pw(input logic [4:0] a, input logic [7:0] d);
		pwe <= 1'b1;
		pa <= a;
		pd <= d;
		@(posedge clk);
	endtask
	task run(input logic [7:0] c, input logic [1:0] r);
		pwe <= 1'b0;
		start <= 1'b1;
		cmd <= c;
		@(posedge clk);
		start <= 1'b0;
		for (int i = 0; i < 200 && done !== 1'b1; i++)
			@(posedge clk);
		chk({done, res}, {1'b1, r});
		@(posedge clk);
	endtask
	task rb(input logic [7:0] a, input logic [7:0] e);
		ra <= a;
		@(posedge clk);
		@(posedge clk);
		chk(rd, e);
	endtask
	function automatic logic [127:0] vblk(input logic [31:0] v, input logic [7:0] a);
		return {~a, a, ~a, a, v, ~v, v};
	endfunction
	localparam logic [39:0] VA = 40'h5A87654321;
	initial begin
		{rst_n, start, pwe, deny} = 4'h0;
		{cmd, pd, ra, pa, lat} = 33'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		pw(5'h00, 8'h05);
		for (int i = 0; i < 5; i++)
			pw(5'(i + 1), VA[8 * i +: 8]);
		pw(5'h06, 8'hA7);
		run(8'h0B, 2'h0);
		chk(i_tag.mem[5], vblk(VA[31:0], VA[39:32]));
		chk({akb, ai, aix}, {2'h2, 6'h27});
		chk({ab, ba}, 16'h0505);
		$display("test write value done");
		lat <= 4'h5;
		pw(5'h01, 8'hFE);
		pw(5'h02, 8'h67);
		for (int i = 0; i < 6; i++)
			pw(5'(i + 3), 8'(17 * i + 17));
		run(8'h0A, 2'h0);
		chk({akb, ai, ak}, {2'h1, 48'h665544332211});
		for (int i = 0; i < 5; i++)
			rb(8'(254 + i), VA[8 * i +: 8]);
		$display("test read value done");
		pw(5'h00, 8'h09);
		deny <= 1'b1;
		run(8'h0A, 2'h1);
		deny <= 1'b0;
		rb(8'hFE, 8'h21);
		pw(5'h00, 8'h07);
		run(8'h0A, 2'h2);
		rb(8'h02, 8'h5A);
		pw(5'h02, 8'h28);
		run(8'h0A, 2'h1);
		run(8'h0C, 2'h3);
		$display("test refusals done");
		conclude();
	end
endmodule // testbench
bind vbce_top vbce_asserts u_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .start_i(start_i),
	.cmd_i(cmd_i), .busy_o(busy_o), .done_o(done_o), .result_o(result_o), .auth_req_o(auth_req_o),
	.auth_inline_o(auth_inline_o), .auth_key_idx_o(auth_key_idx_o), .auth_key_o(auth_key_o),
	.auth_done_i(auth_done_i), .auth_ok_i(auth_ok_i), .blk_rd_req_o(blk_rd_req_o),
	.blk_wr_req_o(blk_wr_req_o), .blk_wdata_o(blk_wdata_o), .blk_done_i(blk_done_i),
	.blk_ok_i(blk_ok_i), .blk_rdata_i(blk_rdata_i));
`default_nettype wire
